//--- hw/mps_defines.vh
// Constants for the program sequencer core: opcodes, ALU functions, registers, phases
`ifndef MPS_DEFINES_VH
`define MPS_DEFINES_VH

// Instruction fields
`define MPS_OP_HI       15
`define MPS_OP_LO       12
`define MPS_FN_HI       11
`define MPS_FN_LO       8
`define MPS_DEST_BIT    7
`define MPS_IMM_HI      7
`define MPS_ADDR_HI     11
`define MPS_DADDR_HI    6

// Opcodes
`define MPS_OP_NOP      4'h0
`define MPS_OP_ALU_A    4'h1
`define MPS_OP_ALU_M    4'h2
`define MPS_OP_SKIP     4'h3
`define MPS_OP_JMP      4'h4
`define MPS_OP_CALL     4'h5
`define MPS_OP_RET      4'h6
`define MPS_OP_INTERRUPT_EXIT_OP     4'h7

// Skip sub-functions
`define MPS_SK_SZ       4'h0
`define MPS_SK_SNZ      4'h1
`define MPS_SK_SIZ      4'h2
`define MPS_SK_SDZ      4'h3

// ALU functions
`define MPS_FN_ADD      4'h0
`define MPS_FN_ADC      4'h1
`define MPS_FN_SUB      4'h2
`define MPS_FN_SBC      4'h3
`define MPS_FN_DAA      4'h4
`define MPS_FN_AND      4'h5
`define MPS_FN_OR       4'h6
`define MPS_FN_XOR      4'h7
`define MPS_FN_CPL      4'h8
`define MPS_FN_RR       4'h9
`define MPS_FN_RRC      4'ha
`define MPS_FN_RL       4'hb
`define MPS_FN_RLC      4'hc
`define MPS_FN_INC      4'hd
`define MPS_FN_DEC      4'he
`define MPS_FN_MOV      4'hf

// Status flag positions and masks
`define MPS_ST_C        0
`define MPS_ST_AC       1
`define MPS_ST_Z        2
`define MPS_ST_OV       3
`define MPS_M_ALL       4'hf
`define MPS_M_Z         4'h4
`define MPS_M_CZ        4'h5
`define MPS_M_C         4'h1

// One-hot phase codes
`define MPS_PH_T1       4'b0001
`define MPS_PH_T2       4'b0010
`define MPS_PH_T3       4'b0100
`define MPS_PH_T4       4'b1000

// Register offsets and status layout
`define MPS_REG_PCL     8'h00
`define MPS_REG_STAT    8'h04
`define MPS_REG_ACC     8'h08
`define MPS_STAT_CNT_LO 8
`define MPS_STAT_FULL   12

// Reset values
`define MPS_PC_RST      12'h000
`define MPS_ACC_RST     8'h00
`define MPS_ST_RST      4'h0
`define MPS_PH_RST      `MPS_PH_T1

`endif

//--- hw/mps_core.v
// Program sequencer: phases, pipeline, program counter, return stack, ALU, APB slave
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.vh"

module mps_core #(
  parameter              STK_DEPTH  = 8,        // Return stack levels
  parameter              STK_PTR_W  = 3,        // Stack pointer width
  parameter [11:0]       INT_VECTOR = 12'h004   // Interrupt entry address
) (
  input  wire            pclk,                  // System clock
  input  wire            presetn,               // Async reset, active low
  input  wire            clk_en,                // Clock enable, freezes all state
  input  wire            psel,                  // APB select
  input  wire            penable,               // APB enable
  input  wire            pwrite,                // APB write
  input  wire [7:0]      paddr,                 // APB byte address
  input  wire [31:0]     pwdata,                // APB write data
  output wire [31:0]     prdata,                // APB read data
  output wire            pready,                // APB ready
  output wire            pslverr,               // APB error, unmapped address
  output wire [11:0]     imem_addr,             // Program memory address
  input  wire [15:0]     imem_rdata,            // Program memory word
  output wire [6:0]      dmem_addr,             // Data memory address
  input  wire [7:0]      dmem_rdata,            // Data memory read data
  output wire [7:0]      dmem_wdata,            // Data memory write data
  output wire            dmem_we,               // Data memory write strobe
  input  wire            int_req,               // Enabled interrupt request
  output wire            int_ack,               // Interrupt acknowledge pulse
  output wire [3:0]      instruction_cycle_phases // One-hot phase
);

  localparam [3:0] PH_T1 = `MPS_PH_T1;
  localparam [3:0] PH_T2 = `MPS_PH_T2;
  localparam [3:0] PH_T3 = `MPS_PH_T3;
  localparam [3:0] PH_T4 = `MPS_PH_T4;

  ////////////////////////////////////////////////////////////////////////////////
  // ALU: returns {flag mask, ov, z, ac, c, result}
  function [15:0] mps_alu;
    input [3:0] fn;
    input [7:0] a;
    input [7:0] b;
    input [3:0] st;
    reg   [8:0] s;
    reg   [4:0] h;
    reg   [7:0] bb;
    reg   [7:0] r;
    reg   [3:0] m;
    reg         ci;
    reg         c;
    reg         ac;
    reg         ov;
    begin
      s  = 9'h000;
      h  = 5'h00;
      bb = b;
      r  = 8'h00;
      m  = `MPS_M_Z;
      ci = 1'b0;
      c  = st[`MPS_ST_C];
      ac = st[`MPS_ST_AC];
      ov = st[`MPS_ST_OV];
      case (fn)
        `MPS_FN_ADD, `MPS_FN_ADC, `MPS_FN_SUB, `MPS_FN_SBC: begin
          if ((fn == `MPS_FN_SUB) || (fn == `MPS_FN_SBC))
            bb = ~b;
          if ((fn == `MPS_FN_ADC) || (fn == `MPS_FN_SBC))
            ci = st[`MPS_ST_C];
          else if (fn == `MPS_FN_SUB)
            ci = 1'b1;
          s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
          h  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
          r  = s[7:0];
          c  = s[8];
          ac = h[4];
          ov = (a[7] == bb[7]) && (s[7] != a[7]);
          m  = `MPS_M_ALL;
        end
        `MPS_FN_DAA: begin
          s = {1'b0, a};
          if ((a[3:0] > 4'h9) || st[`MPS_ST_AC])
            s = s + 9'h006;
          if ((s[7:4] > 4'h9) || st[`MPS_ST_C] || s[8])
            s = s + 9'h060;
          r = s[7:0];
          c = s[8] | st[`MPS_ST_C];
          m = `MPS_M_CZ;
        end
        `MPS_FN_AND: r = a & b;
        `MPS_FN_OR:  r = a | b;
        `MPS_FN_XOR: r = a ^ b;
        `MPS_FN_CPL: r = ~b;
        `MPS_FN_RR:  begin
          r = {b[0], b[7:1]};
          m = 4'h0;
        end
        `MPS_FN_RRC: begin
          r = {st[`MPS_ST_C], b[7:1]};
          c = b[0];
          m = `MPS_M_C;
        end
        `MPS_FN_RL:  begin
          r = {b[6:0], b[7]};
          m = 4'h0;
        end
        `MPS_FN_RLC: begin
          r = {b[6:0], st[`MPS_ST_C]};
          c = b[7];
          m = `MPS_M_C;
        end
        `MPS_FN_INC: r = b + 8'h01;
        `MPS_FN_DEC: r = b - 8'h01;
        default:     begin
          r = b;
          m = 4'h0;
        end
      endcase
      mps_alu = {m, ov, (r == 8'h00), ac, c, r};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State
  reg  [3:0]            phase_r;
  reg  [11:0]           pc_r;
  reg  [15:0]           ir_r;
  reg                   ir_vld_r;
  reg  [7:0]            acc_r;
  reg  [3:0]            stat_r;
  reg  [11:0]           stk_mem [0:STK_DEPTH-1];
  reg  [STK_PTR_W-1:0]  stk_top_r;
  reg  [STK_PTR_W:0]    stk_cnt_r;
  reg                   pcl_pend_r;
  reg  [7:0]            pcl_val_r;
  reg  [6:0]            dmem_addr_r;
  reg  [7:0]            dmem_wdata_r;
  reg                   dmem_we_r;
  reg                   int_ack_r;
  reg  [31:0]           prdata_r;
  reg                   pready_r;
  reg                   pslverr_r;

  // Decode and execute terms
  reg                   t4;
  reg                   exe;
  reg  [3:0]            fn;
  reg  [7:0]            opnd;
  reg  [15:0]           alu_o;
  reg                   redir;
  reg  [11:0]           tgt;
  reg                   push;
  reg                   pop;
  reg                   wr_acc;
  reg                   wr_mem;
  reg                   wr_st;
  reg                   ack;
  reg                   redir_nxt;
  reg  [11:0]           pc_nxt;

  wire [3:0]            op      = ir_r[`MPS_OP_HI:`MPS_OP_LO];
  wire [3:0]            sub     = ir_r[`MPS_FN_HI:`MPS_FN_LO];
  wire                  dest_m  = ir_r[`MPS_DEST_BIT];
  wire                  stk_full = (stk_cnt_r == STK_DEPTH[STK_PTR_W:0]);
  wire [STK_PTR_W-1:0]  stk_pop_idx = stk_top_r - {{(STK_PTR_W-1){1'b0}}, 1'b1};
  wire                  apb_acc = psel & penable & pready_r;
  wire                  apb_wr  = apb_acc & pwrite & ~pslverr_r;
  wire                  pcl_wr  = apb_wr & (paddr == `MPS_REG_PCL);

  ////////////////////////////////////////////////////////////////////////////////
  // Execute stage, resolved in the last phase of each cycle
  always @* begin
    t4     = (phase_r == PH_T4);
    exe    = t4 & ir_vld_r;
    fn     = sub;
    if (op == `MPS_OP_SKIP) begin
      case (sub)
        `MPS_SK_SIZ: fn = `MPS_FN_INC;
        `MPS_SK_SDZ: fn = `MPS_FN_DEC;
        default:     fn = `MPS_FN_MOV;
      endcase
    end
    opnd   = (op == `MPS_OP_ALU_A) ? ir_r[`MPS_IMM_HI:0] : dmem_rdata;
    alu_o  = mps_alu(fn, acc_r, opnd, stat_r);
    redir  = 1'b0;
    tgt    = pc_r;
    push   = 1'b0;
    pop    = 1'b0;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    wr_st  = 1'b0;
    ack    = 1'b0;
    if (exe) begin
      case (op)
        `MPS_OP_ALU_A: begin
          wr_acc = 1'b1;
          wr_st  = 1'b1;
        end
        `MPS_OP_ALU_M: begin
          wr_mem = dest_m;
          wr_acc = ~dest_m;
          wr_st  = 1'b1;
        end
        `MPS_OP_SKIP: begin
          wr_mem = dest_m & ((sub == `MPS_SK_SIZ) | (sub == `MPS_SK_SDZ));
          wr_acc = ~dest_m & ((sub == `MPS_SK_SIZ) | (sub == `MPS_SK_SDZ));
          if ((sub == `MPS_SK_SNZ) ? (alu_o[7:0] != 8'h00) : (alu_o[7:0] == 8'h00)) begin
            redir = 1'b1;
            tgt   = pc_r + 12'h001;
          end
        end
        `MPS_OP_JMP: begin
          redir = 1'b1;
          tgt   = ir_r[`MPS_ADDR_HI:0];
        end
        `MPS_OP_CALL: begin
          push  = 1'b1;
          redir = 1'b1;
          tgt   = ir_r[`MPS_ADDR_HI:0];
        end
        `MPS_OP_RET, `MPS_OP_INTERRUPT_EXIT_OP: begin
          pop   = 1'b1;
          redir = 1'b1;
          tgt   = stk_mem[stk_pop_idx];
        end
        default: ;
      endcase
    end
    // Interrupt only in a cycle with no other redirect and a free level
    if (t4 && !redir && int_req && !stk_full && !pcl_pend_r && !pcl_wr) begin
      push  = 1'b1;
      redir = 1'b1;
      tgt   = INT_VECTOR;
      ack   = 1'b1;
    end
    // Low byte write takes the jump within the current page
    redir_nxt = redir | pcl_pend_r;
    pc_nxt    = pcl_pend_r ? {pc_r[11:8], pcl_val_r} : tgt;
    if (!redir_nxt)
      pc_nxt  = pc_r + 12'h001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Phase sequencer, one-hot
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= `MPS_PH_RST;
    end else if (clk_en) begin
      case (phase_r)
        PH_T1:   phase_r <= PH_T2;
        PH_T2:   phase_r <= PH_T3;
        PH_T3:   phase_r <= PH_T4;
        PH_T4:   phase_r <= PH_T1;
        default: phase_r <= PH_T1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fetch, program counter, accumulator and status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r     <= `MPS_PC_RST;
      ir_r     <= 16'h0000;
      ir_vld_r <= 1'b0;
      acc_r    <= `MPS_ACC_RST;
      stat_r   <= `MPS_ST_RST;
    end else if (clk_en && t4) begin
      ir_r     <= imem_rdata;
      ir_vld_r <= ~redir_nxt;
      pc_r     <= pc_nxt;
      if (wr_acc)
        acc_r  <= alu_o[7:0];
      if (wr_st)
        stat_r <= (stat_r & ~alu_o[15:12]) | (alu_o[11:8] & alu_o[15:12]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Return stack, circular so an overflowing push drops the oldest entry
  always @(posedge pclk) begin
    if (clk_en && push)
      stk_mem[stk_top_r] <= pc_r;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stk_top_r <= {STK_PTR_W{1'b0}};
      stk_cnt_r <= {(STK_PTR_W+1){1'b0}};
    end else if (clk_en) begin
      if (push) begin
        stk_top_r <= stk_top_r + {{(STK_PTR_W-1){1'b0}}, 1'b1};
        if (!stk_full)
          stk_cnt_r <= stk_cnt_r + {{STK_PTR_W{1'b0}}, 1'b1};
      end else if (pop) begin
        stk_top_r <= stk_pop_idx;
        if (stk_cnt_r != {(STK_PTR_W+1){1'b0}})
          stk_cnt_r <= stk_cnt_r - {{STK_PTR_W{1'b0}}, 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data memory port and interrupt acknowledge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dmem_addr_r  <= 7'h00;
      dmem_wdata_r <= 8'h00;
      dmem_we_r    <= 1'b0;
      int_ack_r    <= 1'b0;
    end else if (clk_en) begin
      if (phase_r == PH_T1)
        dmem_addr_r <= ir_r[`MPS_DADDR_HI:0];                   // Operand address
      dmem_we_r    <= wr_mem;
      if (wr_mem)
        dmem_wdata_r <= alu_o[7:0];
      int_ack_r    <= ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      pcl_pend_r <= 1'b0;
      pcl_val_r  <= 8'h00;
    end else if (clk_en) begin
      pready_r  <= psel & ~penable;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `MPS_REG_PCL:  prdata_r <= {24'h000000, pc_r[7:0]};
          `MPS_REG_STAT: begin
            prdata_r[`MPS_ST_OV:`MPS_ST_C] <= stat_r;
            prdata_r[`MPS_STAT_CNT_LO+STK_PTR_W:`MPS_STAT_CNT_LO] <= stk_cnt_r;
            prdata_r[`MPS_STAT_FULL] <= stk_full;
          end
          `MPS_REG_ACC:  prdata_r <= {24'h000000, acc_r};
          default:       pslverr_r <= 1'b1;
        endcase
      end
      // Write wins over the consumption at the phase boundary
      if (pcl_wr) begin
        pcl_pend_r <= 1'b1;
        pcl_val_r  <= pwdata[7:0];
      end else if (t4) begin
        pcl_pend_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata                   = prdata_r;
  assign pready                   = pready_r;
  assign pslverr                  = pslverr_r;
  assign imem_addr                = pc_r;
  assign dmem_addr                = dmem_addr_r;
  assign dmem_wdata               = dmem_wdata_r;
  assign dmem_we                  = dmem_we_r;
  assign int_ack                  = int_ack_r;
  assign instruction_cycle_phases = phase_r;

endmodule
`default_nettype wire

//--- dv/mps_core_sva.sv
// Port-level assertions for the program sequencer core
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.vh"
module mps_core_sva #(
  parameter [11:0]  INT_VECTOR = 12'h004      // Interrupt entry address
) (
  input wire        pclk,                     // System clock
  input wire        presetn,                  // Reset, active low
  input wire        clk_en,                   // Clock enable
  input wire        psel,                     // APB select
  input wire        penable,                  // APB enable
  input wire        pwrite,                   // APB write
  input wire [7:0]  paddr,                    // APB address
  input wire [31:0] pwdata,                   // APB write data
  input wire [31:0] prdata,                   // APB read data
  input wire        pready,                   // APB ready
  input wire        pslverr,                  // APB error
  input wire [11:0] imem_addr,                // Program address
  input wire        dmem_we,                  // Data write strobe
  input wire        int_req,                  // Interrupt request
  input wire        int_ack,                  // Interrupt acknowledge
  input wire [3:0]  instruction_cycle_phases  // One-hot phase
);
  wire [3:0] ph = instruction_cycle_phases;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Low byte of the last accepted counter write
  logic [7:0] pcl_d;
  wire        pcl_wr = psel && penable && pready && pwrite && (paddr == `MPS_REG_PCL);
  always @(posedge pclk) begin
    if (pcl_wr) pcl_d <= pwdata[7:0];
  end

  // Low byte write lands on the counter within two instruction cycles
  property pcl_jump_p;
    pcl_wr |-> ##[1:8] imem_addr[7:0] == pcl_d;
  endproperty

  ////////////////////////////////////////////////////////////////////////
  // Phase ring, counter timing and interrupt acknowledge
  // Reset sampled high keeps the release edge out of the ring check
  chk_phase_ring: assert property (presetn && clk_en |=> ph == {$past(ph[2:0]), $past(ph[3])})
    else $error("phase did not advance");
  chk_phase_hold: assert property (!clk_en |=> $stable(ph) && $stable(imem_addr))
    else $error("state moved while disabled");
  chk_pc_at_t1: assert property ($changed(imem_addr) |-> ph == `MPS_PH_T1)
    else $error("counter moved off the cycle boundary");
  chk_ack_pulse: assert property (int_ack |->
    (ph == `MPS_PH_T1 && imem_addr == INT_VECTOR) ##1 !int_ack)
    else $error("acknowledge without vector load");
  chk_ack_cause: assert property ($rose(int_ack) |-> $past(int_req))
    else $error("acknowledge without request");
  chk_pcl_jump: assert property (pcl_jump_p)
    else $error("low byte write did not jump");
  chk_data_we: assert property (dmem_we |-> (ph == `MPS_PH_T1) ##1 !dmem_we)
    else $error("data write strobe misplaced");

  ////////////////////////////////////////////////////////////////////////
  // Register bus answer
  chk_apb_ready: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |-> $past(psel && !penable) ##1 !pready)
    else $error("ready without setup");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");

  // Main scenarios
  cover property (int_ack);
  cover property (pslverr);
  cover property (dmem_we);
endmodule

bind mps_core mps_core_sva #(.INT_VECTOR(INT_VECTOR)) u_mps_core_sva (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .imem_addr(imem_addr), .dmem_we(dmem_we), .int_req(int_req),
  .int_ack(int_ack), .instruction_cycle_phases(instruction_cycle_phases));
`default_nettype wire

//--- dv/mps_mem_model.sv
// Program memory, data memory and interrupt source around the core
`timescale 1ns/1ps
`default_nettype none
module mps_mem_model (
  input  wire logic        pclk,        // System clock
  input  wire logic        presetn,     // Reset, active low
  input  wire logic [11:0] imem_addr,   // Program address
  output wire logic [15:0] imem_rdata,  // Program word
  input  wire logic [6:0]  dmem_addr,   // Data address
  output wire logic [7:0]  dmem_rdata,  // Data read
  input  wire logic [7:0]  dmem_wdata,  // Data write
  input  wire logic        dmem_we,     // Data write strobe
  input  wire logic        int_raise,   // Bench request pulse
  input  wire logic        int_ack,     // Acknowledge from core
  output var  logic        int_req      // Held request
);
  logic [15:0] rom [0:4095];
  logic [7:0]  ram [0:127];

  // Asynchronous program and data reads
  assign imem_rdata = rom[imem_addr];
  assign dmem_rdata = ram[dmem_addr];

  // Data memory write port
  always @(posedge pclk) begin
    if (dmem_we) ram[dmem_addr] <= dmem_wdata;
  end

  // Request held until acknowledged, dropped one cycle after
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) int_req <= 1'b0;
    else if (int_ack) int_req <= 1'b0;
    else if (int_raise) int_req <= 1'b1;
  end
endmodule
`default_nettype wire

//--- dv/mcu_program_sequencer_tb.sv
// Self-checking bench for the program sequencer core
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.vh"
module mcu_program_sequencer_tb;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, int_raise, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  wire  [31:0] prdata;
  wire         pready, pslverr, dmem_we, int_req, int_ack;
  wire  [11:0] imem_addr;
  wire  [15:0] imem_rdata;
  wire  [6:0]  dmem_addr;
  wire  [7:0]  dmem_rdata, dmem_wdata;
  wire  [3:0]  ph;
  integer      err_count, tests_run, f, acks;
  localparam logic [127:0] ALU_EXP = 128'hd1d15b5a_9612bfad_c49d1d76_763c3a3b;

  mps_core u_mps_core (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .imem_addr(imem_addr), .imem_rdata(imem_rdata),
    .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .dmem_wdata(dmem_wdata),
    .dmem_we(dmem_we), .int_req(int_req), .int_ack(int_ack),
    .instruction_cycle_phases(ph));
  mps_mem_model u_mps_mem_model (.pclk(pclk), .presetn(presetn), .imem_addr(imem_addr),
    .imem_rdata(imem_rdata), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata),
    .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .int_raise(int_raise),
    .int_ack(int_ack), .int_req(int_req));

  // Clock and acknowledge counter
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) acks <= 0;
    else if (int_ack === 1'b1) acks <= acks + 1;
  end

  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task hang(input string name);
    begin
      err_count = err_count + 1;
      $display("BAD %s expected answer seen timeout", name);
      complete_run;
    end
  endtask
  // One APB transfer, answer kept in q and e
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 8) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (pready !== 1'b1) hang("apb ready");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wipe;
    integer i;
    begin
      for (i = 0; i < 512; i = i + 1) u_mps_mem_model.rom[i] = 16'h0000;
    end
  endtask
  task ld(input logic [11:0] a, input logic [15:0] w);
    u_mps_mem_model.rom[a] = w;
  endtask
  task boot;
    begin
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
    end
  endtask
  // Counter value seen at each of six instruction boundaries
  task trace(input logic [71:0] ev);
    integer n, k;
    begin
      n = 0;
      for (k = 0; k < 40 && n < 6; k = k + 1) begin
        @(posedge pclk);
        #1;
        if (ph === `MPS_PH_T1) begin
          chk("pc trace", {20'h0, ev[71-12*n -: 12]}, {20'h0, imem_addr});
          n = n + 1;
        end
      end
      if (n < 6) hang("pc trace");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, int_raise} = 5'h00;
    clk_en = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    tests_run = 0;
    // Every function code on acc 96 and immediate 3b
    for (f = 0; f < 16; f = f + 1) begin
      wipe;
      ld(0, 16'h1f96);
      ld(1, {`MPS_OP_ALU_A, f[3:0], 8'h3b});
      ld(2, 16'h4002);
      boot;
      repeat (32) @(posedge pclk);
      apb(0, `MPS_REG_ACC, 0);
      chk("alu function", {24'h0, ALU_EXP[127-8*f -: 8]}, q);
    end
    // Carry and zero, memory destination
    wipe;
    ld(0, 16'h1f3c); ld(1, 16'h10d0); ld(2, 16'h2590); ld(3, 16'h120c); ld(4, 16'h4004);
    u_mps_mem_model.ram[16] = 8'h0f;
    boot;
    repeat (60) @(posedge pclk);
    apb(0, `MPS_REG_ACC, 0);
    chk("acc result", 32'h0, q);
    apb(0, `MPS_REG_STAT, 0);
    chk("carry zero", 32'h5, q & 32'h5);
    chk("stack empty", 32'h0, q & 32'h1f00);
    chk("mem dest", 32'h0c, {24'h0, u_mps_mem_model.ram[16]});
    // Branch timing, low byte read, refusals, clock enable hold
    wipe;
    ld(1, 16'h4020); ld(12'h020, 16'h4020);
    boot;
    chk("reset pc", 32'h0, {20'h0, imem_addr});
    trace({12'h001, 12'h002, 12'h020, 12'h021, 12'h020, 12'h021});
    apb(0, `MPS_REG_PCL, 0);
    chk("pcl read", 32'h21, q);
    apb(1, `MPS_REG_STAT, 32'h1f00);
    apb(0, `MPS_REG_STAT, 0);
    chk("stack hidden", 32'h0, q & 32'h1f00);
    apb(0, 8'h0c, 0);
    chk("unmapped", 32'h1, {31'h0, e});
    clk_en <= 1'b0;
    repeat (6) @(posedge pclk);
    clk_en <= 1'b1;
    // Call and return resume after the call
    wipe;
    ld(0, 16'h5030); ld(1, 16'h4001); ld(12'h030, 16'h6000);
    boot;
    trace({12'h001, 12'h030, 12'h031, 12'h001, 12'h002, 12'h001});
    // Taken skip discards the next word
    wipe;
    ld(0, 16'h3291); ld(1, 16'h1f55); ld(2, 16'h1f66); ld(3, 16'h4003);
    u_mps_mem_model.ram[17] = 8'hff;
    boot;
    repeat (40) @(posedge pclk);
    apb(0, `MPS_REG_ACC, 0);
    chk("skip acc", 32'h66, q);
    chk("skip mem", 32'h0, {24'h0, u_mps_mem_model.ram[17]});
    // Overflowing calls, held interrupt, low byte jump within the page
    wipe;
    ld(0, 16'h4100); ld(12'h100, 16'h5100); ld(12'h101, 16'h4101);
    ld(12'h140, 16'h6000); ld(12'h004, 16'h7000);
    boot;
    repeat (120) @(posedge pclk);
    apb(0, `MPS_REG_STAT, 0);
    chk("stack full", 32'h1800, q & 32'h1f00);
    int_raise <= 1'b1;
    @(posedge pclk);
    int_raise <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("ack held", 32'h0, acks);
    chk("request kept", 32'h1, {31'h0, int_req});
    apb(1, `MPS_REG_PCL, 32'h40);
    repeat (60) @(posedge pclk);
    chk("ack after pop", 32'h1, acks);
    chk("page kept", 32'h1, {28'h0, imem_addr[11:8]});
    apb(0, `MPS_REG_STAT, 0);
    chk("stack count", 32'h700, q & 32'h1f00);
    complete_run;
  end
endmodule
`default_nettype wire
